/* File: include/ima_defines.svh */
// register map, field positions and reset values of the interrupt acceptance block
// assumes inclusion by the package and the design module only
`ifndef IMA_DEFINES_SVH
`define IMA_DEFINES_SVH

// word indexes on the avalon slave (byte address = index * 4)
`define IMA_REG_PEND_LO 4'h0
`define IMA_REG_PEND_HI 4'h1
`define IMA_REG_EN_LO 4'h2
`define IMA_REG_EN_HI 4'h3
`define IMA_REG_TC_LO 4'h4
`define IMA_REG_TC_HI 4'h5
`define IMA_REG_STAT 4'h6
`define IMA_REG_SAVED 4'h7

// control and status fields
`define IMA_ST_IRQ_DIS 0
`define IMA_ST_DBG_DIS 1
`define IMA_ST_EMU_EN 2
`define IMA_ST_IN_ISR 3
`define IMA_ST_RT_HALT 4
`define IMA_ST_VEC_LSB 8
`define IMA_SAVED_MODE_LSB 16

`define IMA_HALF_W 16
`define IMA_BERR_BIT 0
// global irq disable = 1, debug event disable = 1, emulation access = 0
`define IMA_MODE_RST 3'h6

`endif

/* File: include/ima_pkg.sv */
// types shared by the interrupt acceptance block
// assumes ima_defines.svh on the include path
package ima_pkg;
  `include "ima_defines.svh"

  typedef struct packed {
    logic global_irq_disable;
    logic debug_event_disable;
    logic emu_reg_access_enable;
  } ima_mode_t;

  typedef struct packed {
    logic [15:0] status;
    logic [23:0] pc;
  } ima_cpu_ctx_t;

  typedef struct packed {
    ima_mode_t mode;
    ima_cpu_ctx_t cpu;
  } ima_ctx_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DRAIN,
    ST_ISR
  } ima_state_t;
endpackage

/* File: verilog/ima_pick.sv */
// fixed-priority picker: lowest set index wins
// assumes a purely combinational use inside one clock domain
module ima_pick #(
  parameter int N = 32,
  parameter int W = 5
) (
  input wire logic [N-1:0] i_req,
  output logic o_hit,
  output logic [W-1:0] o_idx
);
  always_comb begin
    o_hit = 1'b0;
    o_idx = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (i_req[k]) begin
        o_hit = 1'b1;
        o_idx = W'(k);
      end
    end
  end
endmodule

/* File: verilog/ima_accept.sv */
// maskable interrupt acceptance: pending, enable, time-critical registers,
// acceptance sequencing towards the cpu, context save and restore
// assumes cpu sequencer signals on i_clk_sys; request pins are asynchronous
//
// How it works
// - a detected request sets and latches its pending flag
// - pending stays set until acknowledged, cleared by software, or reset
// - each interrupt owns one enable bit in the low or high enable register
// - standard flow acknowledges only interrupts whose enable bit is 1
// - standard flow acknowledges only while global disable reads 0
// - each interrupt owns one time-critical bit in the low or high register
// - in real-time halt only time-critical interrupts are taken, separate flow
// - acknowledge hands the vector to the cpu to branch to the routine
// - branch lets decoded instructions finish and flushes younger ones
// - branch clears the acknowledged pending flag
// - branch saves mode and status of the interrupted program
// - branch sets global disable and debug disable, clears emulation access
// - return from interrupt restores the saved values
// - a request not enabled is ignored and the program runs on
// - after the routine the program resumes where it was interrupted
// - bus errors from system or cpu raise the bus error interrupt
module ima_accept #(
  parameter int N_IRQ = 25
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [N_IRQ-1:0] i_irq_req,
  input wire logic i_sys_bus_err,
  input wire logic i_cpu_bus_err,
  input wire logic i_rt_halt,
  input wire logic i_pipe_drained,
  input wire logic i_rti,
  input wire ima_pkg::ima_cpu_ctx_t i_ctx,
  input wire logic [5:0] i_av_address,
  input wire logic i_av_read,
  input wire logic i_av_write,
  input wire logic [31:0] i_av_writedata,
  input wire logic [3:0] i_av_byteenable,
  output logic [31:0] o_av_readdata,
  output logic o_av_waitrequest,
  output logic o_flush_req,
  output logic o_vector_valid,
  output logic [4:0] o_vector_num,
  output logic o_resume_valid,
  output ima_pkg::ima_cpu_ctx_t o_restore_ctx,
  output logic o_global_irq_disable,
  output logic o_debug_event_disable,
  output logic o_emu_reg_access_enable
);
  localparam logic [31:0] IRQ_MASK = {{(32 - N_IRQ){1'b0}}, {N_IRQ{1'b1}}};

  logic [N_IRQ-1:0] sync1_r;
  logic [N_IRQ-1:0] sync2_r;
  logic [N_IRQ-1:0] prev_r;
  logic [31:0] pend_r;
  logic [31:0] en_r;
  logic [31:0] tc_r;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] elig;
  logic [31:0] en_nxt;
  logic [31:0] tc_nxt;
  ima_pkg::ima_mode_t mode_r;
  ima_pkg::ima_mode_t mode_nxt;
  ima_pkg::ima_ctx_t ctx_r;
  ima_pkg::ima_state_t st_r;
  logic [4:0] idx_r;
  logic [4:0] pick_idx;
  logic pick_hit;
  logic pick_go;
  logic ack_go;
  logic rti_go;
  logic waitreq_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_val;
  logic wr_go;
  logic [3:0] widx;
  logic [15:0] lanes;
  logic flush_r;
  logic vec_valid_r;
  logic resume_r;
  ima_pkg::ima_cpu_ctx_t restore_r;

  // byte lanes of a 16-bit register
  function automatic logic [15:0] lane16(input logic [1:0] be);
    return {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // merge write data into a 16-bit half under its lanes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
    return (old & ~lane16(be)) | (wd & lane16(be));
  endfunction

  // ---------------- avalon slave ----------------
  assign widx = i_av_address[5:2];
  assign wr_go = i_av_write && !waitreq_r;
  assign lanes = lane16(i_av_byteenable[1:0]);

  // one wait cycle for every request, then one cycle with waitrequest low
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      waitreq_r <= 1'b1;
    end else if (waitreq_r && (i_av_read || i_av_write)) begin
      waitreq_r <= 1'b0;
    end else begin
      waitreq_r <= 1'b1;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    case (widx)
      `IMA_REG_PEND_LO: rd_val[15:0] = pend_r[15:0];
      `IMA_REG_PEND_HI: rd_val[15:0] = pend_r[31:16];
      `IMA_REG_EN_LO: rd_val[15:0] = en_r[15:0];
      `IMA_REG_EN_HI: rd_val[15:0] = en_r[31:16];
      `IMA_REG_TC_LO: rd_val[15:0] = tc_r[15:0];
      `IMA_REG_TC_HI: rd_val[15:0] = tc_r[31:16];
      `IMA_REG_STAT: begin
        rd_val[`IMA_ST_IRQ_DIS] = mode_r.global_irq_disable;
        rd_val[`IMA_ST_DBG_DIS] = mode_r.debug_event_disable;
        rd_val[`IMA_ST_EMU_EN] = mode_r.emu_reg_access_enable;
        rd_val[`IMA_ST_IN_ISR] = (st_r == ima_pkg::ST_ISR);
        rd_val[`IMA_ST_RT_HALT] = i_rt_halt;
        rd_val[`IMA_ST_VEC_LSB +: 5] = idx_r;
      end
      `IMA_REG_SAVED: begin
        rd_val[15:0] = ctx_r.cpu.status;
        rd_val[`IMA_SAVED_MODE_LSB +: 3] = ctx_r.mode;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (waitreq_r && i_av_read) begin
      rdata_r <= rd_val;
    end
  end

  // ---------------- request capture ----------------
  // pins pass two flops before the edge detector looks at them
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= i_irq_req;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  always_comb begin
    set_vec = {{(32 - N_IRQ){1'b0}}, sync2_r & ~prev_r};
    set_vec[`IMA_BERR_BIT] = set_vec[`IMA_BERR_BIT] | i_sys_bus_err | i_cpu_bus_err;
    clr_vec = 32'h0000_0000;
    if (wr_go && widx == `IMA_REG_PEND_LO) begin
      clr_vec[15:0] = i_av_writedata[15:0] & lanes;
    end
    if (wr_go && widx == `IMA_REG_PEND_HI) begin
      clr_vec[31:16] = i_av_writedata[15:0] & lanes;
    end
    if (ack_go) begin
      clr_vec = clr_vec | (32'h0000_0001 << idx_r);
    end
  end

  // a new request in the clearing cycle wins over the clear
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pend_r <= 32'h0000_0000;
    end else begin
      pend_r <= ((pend_r & ~clr_vec) | set_vec) & IRQ_MASK;
    end
  end

  // ---------------- enable and time-critical registers ----------------
  always_comb begin
    en_nxt = en_r;
    tc_nxt = tc_r;
    if (wr_go) begin
      case (widx)
        `IMA_REG_EN_LO: en_nxt[15:0] = merge16(en_r[15:0], i_av_writedata[15:0],
                                               i_av_byteenable[1:0]);
        `IMA_REG_EN_HI: en_nxt[31:16] = merge16(en_r[31:16], i_av_writedata[15:0],
                                                i_av_byteenable[1:0]);
        `IMA_REG_TC_LO: tc_nxt[15:0] = merge16(tc_r[15:0], i_av_writedata[15:0],
                                               i_av_byteenable[1:0]);
        `IMA_REG_TC_HI: tc_nxt[31:16] = merge16(tc_r[31:16], i_av_writedata[15:0],
                                                i_av_byteenable[1:0]);
        default: begin
          en_nxt = en_r;
          tc_nxt = tc_r;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      en_r <= 32'h0000_0000;
      tc_r <= 32'h0000_0000;
    end else begin
      en_r <= en_nxt & IRQ_MASK;
      tc_r <= tc_nxt & IRQ_MASK;
    end
  end

  // ---------------- acceptance ----------------
  always_comb begin
    if (i_rt_halt) begin
      elig = pend_r & en_r & tc_r;
    end else if (mode_r.global_irq_disable) begin
      elig = 32'h0000_0000;
    end else begin
      elig = pend_r & en_r;
    end
  end

  ima_pick #(
    .N(32),
    .W(5)
  ) u_ima_pick (
    .i_req(elig),
    .o_hit(pick_hit),
    .o_idx(pick_idx)
  );

  assign pick_go = (st_r == ima_pkg::ST_IDLE) && pick_hit;
  assign ack_go = (st_r == ima_pkg::ST_DRAIN) && i_pipe_drained;
  assign rti_go = (st_r == ima_pkg::ST_ISR) && i_rti;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_r <= ima_pkg::ST_IDLE;
      idx_r <= 5'h00;
    end else begin
      case (st_r)
        ima_pkg::ST_IDLE: begin
          if (pick_go) begin
            st_r <= ima_pkg::ST_DRAIN;
            idx_r <= pick_idx;
          end
        end
        ima_pkg::ST_DRAIN: begin
          if (ack_go) begin
            st_r <= ima_pkg::ST_ISR;
          end
        end
        ima_pkg::ST_ISR: begin
          if (rti_go) begin
            st_r <= ima_pkg::ST_IDLE;
          end
        end
        default: st_r <= ima_pkg::ST_IDLE;
      endcase
    end
  end

  // flush request stands from selection until the pipeline reports drained
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      flush_r <= 1'b0;
    end else begin
      flush_r <= pick_go || (flush_r && !ack_go);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      vec_valid_r <= 1'b0;
    end else begin
      vec_valid_r <= ack_go;
    end
  end

  // ---------------- context ----------------
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ctx_r <= '0;
    end else if (ack_go) begin
      ctx_r <= {mode_r, i_ctx};
    end
  end

  always_comb begin
    mode_nxt = mode_r;
    if (wr_go && widx == `IMA_REG_STAT && i_av_byteenable[0]) begin
      mode_nxt.global_irq_disable = i_av_writedata[`IMA_ST_IRQ_DIS];
      mode_nxt.debug_event_disable = i_av_writedata[`IMA_ST_DBG_DIS];
      mode_nxt.emu_reg_access_enable = i_av_writedata[`IMA_ST_EMU_EN];
    end
    if (rti_go) begin
      mode_nxt = ctx_r.mode;
    end
    if (ack_go) begin
      mode_nxt.global_irq_disable = 1'b1;
      mode_nxt.debug_event_disable = 1'b1;
      mode_nxt.emu_reg_access_enable = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      mode_r <= `IMA_MODE_RST;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      resume_r <= 1'b0;
      restore_r <= '0;
    end else begin
      resume_r <= rti_go;
      if (rti_go) begin
        restore_r <= ctx_r.cpu;
      end
    end
  end

  assign o_av_readdata = rdata_r;
  assign o_av_waitrequest = waitreq_r;
  assign o_flush_req = flush_r;
  assign o_vector_valid = vec_valid_r;
  assign o_vector_num = idx_r;
  assign o_resume_valid = resume_r;
  assign o_restore_ctx = restore_r;
  assign o_global_irq_disable = mode_r.global_irq_disable;
  assign o_debug_event_disable = mode_r.debug_event_disable;
  assign o_emu_reg_access_enable = mode_r.emu_reg_access_enable;

  // ---------------- assertions ----------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_drained;
    (st_r == ima_pkg::ST_DRAIN) && i_pipe_drained;
  endsequence

  sequence s_return;
    (st_r == ima_pkg::ST_ISR) && i_rti;
  endsequence

  a_pend_latch: assert property (
    (set_vec != 32'h0000_0000) |=> ((pend_r & $past(set_vec & IRQ_MASK))
                                    == $past(set_vec & IRQ_MASK)))
    else $error("pending flag not set by request");

  a_pend_hold: assert property (
    1'b1 |=> ((($past(pend_r) & ~$past(clr_vec)) & ~pend_r) == 32'h0000_0000))
    else $error("pending flag dropped without a clear");

  a_ack_enable: assert property (
    pick_go |-> en_r[pick_idx])
    else $error("disabled interrupt selected");

  a_ack_global: assert property (
    (pick_go && !i_rt_halt) |-> !mode_r.global_irq_disable)
    else $error("interrupt taken while globally disabled");

  a_rt_critical: assert property (
    (pick_go && i_rt_halt) |-> tc_r[pick_idx])
    else $error("non time-critical interrupt taken in halt");

  a_prio_order: assert property (
    pick_go |-> ((elig & ((32'h0000_0001 << pick_idx) - 32'h0000_0001)) == 32'h0000_0000))
    else $error("lower priority interrupt taken first");

  a_branch_entry: assert property (
    s_drained |=> o_vector_valid && o_global_irq_disable && o_debug_event_disable
                  && !o_emu_reg_access_enable && !o_flush_req)
    else $error("branch entry context wrong");

  a_flush_wait: assert property (
    (pick_go || (o_flush_req && !i_pipe_drained)) |=> o_flush_req)
    else $error("flush request dropped before drain");

  a_pend_clear: assert property (
    (s_drained and !set_vec[idx_r]) |=> !pend_r[$past(idx_r)])
    else $error("acknowledged flag not cleared");

  a_ctx_restore: assert property (
    s_return |=> o_resume_valid && (o_restore_ctx == $past(ctx_r.cpu))
                 && (o_global_irq_disable == $past(ctx_r.mode.global_irq_disable)))
    else $error("context not restored on return");

  a_berr_raise: assert property (
    (i_sys_bus_err || i_cpu_bus_err) |=> pend_r[`IMA_BERR_BIT])
    else $error("bus error interrupt not raised");

  a_bus_answer: assert property (
    ((i_av_read || i_av_write) && o_av_waitrequest) |=> !o_av_waitrequest ##1 o_av_waitrequest)
    else $error("avalon answer timing wrong");
endmodule

/* File: verif/ima_req_model.sv */
// request pins and a cpu sequencer that drains its pipeline on request
// assumes the acceptance block on the same clock; pin 0 is never driven
module ima_req_model (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_fire,
  input wire logic [4:0] i_fire_idx,
  input wire logic [3:0] i_drain_dly,
  input wire logic i_flush_req,
  output logic [24:0] o_irq_req,
  output logic o_pipe_drained
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hold_r;
  logic [3:0] cnt_r;

  // a pin stays high a few cycles so the synchroniser sees one edge
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_irq_req <= '0;
      hold_r <= 3'h0;
    end else if (i_fire) begin
      o_irq_req <= 25'(1) << i_fire_idx;
      hold_r <= 3'h4;
    end else if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
    end else begin
      o_irq_req <= '0;
    end
  end

  // decoded work finishes after a chosen delay, then drained holds
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !i_flush_req) begin
      cnt_r <= 4'h0;
    end else if (cnt_r != 4'hF) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  assign o_pipe_drained = i_flush_req && (cnt_r >= i_drain_dly);
endmodule

/* File: verif/tb_ima_accept.sv */
// self-checking bench for the interrupt acceptance block
// assumes the request and cpu model beside it and one 250 MHz clock
module tb_ima_accept;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fire = 1'b0;
  logic [4:0] fire_idx = 5'h00;
  logic [3:0] dly = 4'h3;
  logic sys_berr = 1'b0;
  logic cpu_berr = 1'b0;
  logic rt_halt = 1'b0;
  logic rti = 1'b0;
  ima_pkg::ima_cpu_ctx_t ctx = '0;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'h0;
  logic [24:0] irq;
  logic [31:0] rdata;
  logic [4:0] vec_num;
  logic drained, waitreq, flush, vec_valid, res_valid, irq_dis, dbg_dis, emu_en;
  ima_pkg::ima_cpu_ctx_t res_ctx;
  int num_errors = 0;
  int compares = 0;

  always #2 clk = ~clk;

  ima_accept #(.N_IRQ(25)) u_ima_accept (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_irq_req(irq), .i_sys_bus_err(sys_berr),
    .i_cpu_bus_err(cpu_berr), .i_rt_halt(rt_halt), .i_pipe_drained(drained),
    .i_rti(rti), .i_ctx(ctx), .i_av_address(adr), .i_av_read(rd), .i_av_write(wr),
    .i_av_writedata(wdata), .i_av_byteenable(be), .o_av_readdata(rdata),
    .o_av_waitrequest(waitreq), .o_flush_req(flush), .o_vector_valid(vec_valid),
    .o_vector_num(vec_num), .o_resume_valid(res_valid), .o_restore_ctx(res_ctx),
    .o_global_irq_disable(irq_dis), .o_debug_event_disable(dbg_dis),
    .o_emu_reg_access_enable(emu_en)
  );

  ima_req_model u_ima_req_model (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_fire(fire), .i_fire_idx(fire_idx),
    .i_drain_dly(dly), .i_flush_req(flush), .o_irq_req(irq), .o_pipe_drained(drained)
  );

  task automatic end_of_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tmo(input string what);
    num_errors++;
    $display("CHECK FAILED %s expected answer seen timeout", what);
    end_of_test();
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic av(input logic w, input logic [5:0] a, input logic [15:0] d,
                    output logic [31:0] q);
    int n;
    adr <= a;
    wdata <= {16'h0000, d};
    be <= 4'h3;
    rd <= ~w;
    wr <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (waitreq !== 1'b0) tmo("bus answer");
    @(posedge clk);
  endtask

  // 0 flush, 1 vector, 2 resume; n counts edges until seen
  task automatic wait_on(input int w, output int n);
    logic s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      s = (w == 0) ? flush : (w == 1) ? vec_valid : res_valid;
    end while (s !== 1'b1 && n < 200);
    if (s !== 1'b1) tmo("handshake");
  endtask

  task automatic no_take(input string what);
    logic hit;
    hit = 1'b0;
    repeat (24) begin
      @(posedge clk);
      if (flush !== 1'b0) hit = 1'b1;
    end
    chk(what, 1'b0, hit);
  endtask

  task automatic fire_irq(input logic [4:0] idx);
    fire <= 1'b1;
    fire_idx <= idx;
    @(posedge clk);
    fire <= 1'b0;
    repeat (7) @(posedge clk);
  endtask

  task automatic berr(input logic sys);
    sys_berr <= sys;
    cpu_berr <= ~sys;
    @(posedge clk);
    sys_berr <= 1'b0;
    cpu_berr <= 1'b0;
    @(posedge clk);
  endtask

  // full acceptance, service and return of one interrupt
  task automatic take(input logic [4:0] idx, input logic [2:0] mode);
    int n;
    logic [31:0] lo, hi, q;
    ima_pkg::ima_cpu_ctx_t c;
    wait_on(0, n);
    wait_on(1, n);
    c = ctx;
    chk("drain to branch", dly + 4'h1, n);
    chk("vector", idx, vec_num);
    chk("flush after branch", 1'b0, flush);
    chk("fresh mode", 3'h6, {irq_dis, dbg_dis, emu_en});
    ctx <= ~c;
    av(1'b0, 6'h00, 16'h0000, lo);
    av(1'b0, 6'h04, 16'h0000, hi);
    q = {hi[15:0], lo[15:0]};
    chk("ack clear", 1'b0, q[idx]);
    av(1'b0, 6'h1C, 16'h0000, q);
    chk("saved context", {mode, c.status}, q[18:0]);
    rti <= 1'b1;
    @(posedge clk);
    rti <= 1'b0;
    wait_on(2, n);
    chk("resume delay", 1, n);
    chk("restore", c, res_ctx);
    chk("restored mode", mode, {irq_dis, dbg_dis, emu_en});
  endtask

  task automatic t_reset();
    logic [31:0] q;
    chk("idle outputs", 3'h0, {flush, vec_valid, res_valid});
    chk("reset mode", 3'h6, {irq_dis, dbg_dis, emu_en});
    av(1'b0, 6'h18, 16'h0000, q);
    chk("status reset", 32'h0000_0003, q);
    av(1'b0, 6'h00, 16'h0000, q);
    chk("pending reset", 32'h0000_0000, q);
    av(1'b0, 6'h20, 16'h0000, q);
    chk("unmapped read", 32'h0000_0000, q);
    $display("test reset done");
  endtask

  task automatic t_std();
    logic [31:0] q;
    av(1'b1, 6'h18, 16'h0004, q);
    fire_irq(5'h14);
    no_take("disabled request");
    av(1'b0, 6'h04, 16'h0000, q);
    chk("pending latched", 32'h0000_0010, q);
    av(1'b1, 6'h18, 16'h0005, q);
    av(1'b1, 6'h0C, 16'h0010, q);
    no_take("global disable");
    ctx <= 40'hA5_1234_5678;
    av(1'b1, 6'h18, 16'h0004, q);
    take(5'h14, 3'h1);
    $display("test standard flow done");
  endtask

  task automatic t_prio();
    logic [31:0] q;
    dly <= 4'h0;
    av(1'b1, 6'h18, 16'h0001, q);
    av(1'b1, 6'h08, 16'h0081, q);
    berr(1'b1);
    av(1'b0, 6'h00, 16'h0000, q);
    chk("system bus error", 32'h0000_0001, q);
    av(1'b1, 6'h00, 16'h0001, q);
    berr(1'b0);
    fire_irq(5'h07);
    fire_irq(5'h09);
    av(1'b1, 6'h00, 16'h0200, q);
    av(1'b0, 6'h00, 16'h0000, q);
    chk("software clear", 32'h0000_0081, q);
    ctx <= 40'h3C_0F0F_1234;
    av(1'b1, 6'h18, 16'h0000, q);
    take(5'h00, 3'h0);
    take(5'h07, 3'h0);
    $display("test priority done");
  endtask

  task automatic t_rt();
    logic [31:0] q;
    dly <= 4'h2;
    av(1'b1, 6'h18, 16'h0001, q);
    av(1'b1, 6'h08, 16'h0008, q);
    rt_halt <= 1'b1;
    av(1'b0, 6'h18, 16'h0000, q);
    chk("status in halt", 32'h0000_0711, q);
    fire_irq(5'h03);
    no_take("halt without time-critical");
    ctx <= 40'h5A_8765_4321;
    av(1'b1, 6'h10, 16'h0008, q);
    take(5'h03, 3'h4);
    rt_halt <= 1'b0;
    $display("test real-time halt done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_std();
    t_prio();
    t_rt();
    end_of_test();
  end
endmodule
